// ===== verilog/sfc_pkg.sv
// shared constants and types for the flash command and status unit
package sfc_pkg;
	localparam int          ADDR_W        = 21;
	localparam int          DATA_W        = 16;
	localparam int          NUM_BLOCKS    = 16;
	localparam int          BLK_W         = 4;
	localparam int          BLK_LSB       = 17;
	localparam int          MEM_W         = 8;
	// command codes, low byte only
	localparam logic [7:0]  CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0]  CMD_IDENT      = 8'h90;
	localparam logic [7:0]  CMD_READ_STAT  = 8'h70;
	localparam logic [7:0]  CMD_CLEAR      = 8'h50;
	localparam logic [7:0]  CMD_WRITE      = 8'h40;
	localparam logic [7:0]  CMD_WRITE_ALT  = 8'h10;
	localparam logic [7:0]  CMD_ERASE      = 8'h20;
	localparam logic [7:0]  CMD_SUSPEND    = 8'hB0;
	localparam logic [7:0]  CMD_CONFIRM    = 8'hD0;
	localparam logic [7:0]  CMD_READ_XSTAT = 8'h71;
	localparam logic [7:0]  CMD_LOCK       = 8'h77;
	localparam logic [7:0]  CMD_UPLOAD     = 8'h97;
	localparam logic [7:0]  CMD_CONFIG     = 8'h96;
	// block status bits kept in the memory
	localparam int          BLK_FAIL_BIT   = 5;
	localparam int          BLK_SUPPLY_BIT = 2;
	// configuration byte
	localparam int          CFG_LAT_LSB    = 3;
	localparam logic [2:0]  LAT_DEFAULT    = 3'h4;
	localparam logic [2:0]  LAT_MIN        = 3'h1;
	localparam logic [2:0]  LAT_MAX        = 3'h4;
	// extended status register select, word index within a block
	localparam int          XSEL_LSB       = 1;
	localparam logic [1:0]  XSEL_BLOCK     = 2'h1;
	localparam logic [1:0]  XSEL_GLOBAL    = 2'h2;
	// identifier values are arbitrary
	localparam logic [15:0] MFR_CODE_DEF   = 16'h0055;
	localparam logic [15:0] DEV_CODE_DEF   = 16'h7A3E;
	// operation lengths in clock cycles
	localparam int          WRITE_CYC_DEF  = 16;
	localparam int          ERASE_CYC_DEF  = 256;
	localparam int          LOCK_CYC_DEF   = 16;
	localparam int          UPLOAD_CYC_DEF = 16;
	localparam int          CNT_W          = 12;

	typedef enum logic [1:0] {RM_ARRAY, RM_IDENT, RM_STATUS, RM_XSTATUS} sfc_read_mode_t;
	typedef enum logic [2:0] {PD_NONE, PD_WRITE, PD_ERASE, PD_LOCK, PD_UPLOAD, PD_CONFIG}
		sfc_pend_t;
	typedef enum logic [2:0] {MS_IDLE, MS_WRITE, MS_ERASE, MS_LOCK, MS_UPLOAD, MS_SUSPEND}
		sfc_machine_t;
endpackage : sfc_pkg

// ===== verilog/sfc_mem_if.sv
// per-block status memory port bundle
`timescale 1ns/1ps
interface sfc_mem_if #(
	parameter int N = 16,
	parameter int W = 8
);
	logic                 wrEn;
	logic [$clog2(N)-1:0] wrIdx;
	logic [W-1:0]         wrSet;
	logic [W-1:0]         clrAll;
	logic [$clog2(N)-1:0] rdIdx;
	logic [W-1:0]         rdData;
	modport ctrl (output wrEn, wrIdx, wrSet, clrAll, rdIdx, input rdData);
	modport mem  (input wrEn, wrIdx, wrSet, clrAll, rdIdx, output rdData);
endinterface : sfc_mem_if

// ===== verilog/sfc_block_mem.sv
// per-block status flag memory with registered read
`timescale 1ns/1ps
module sfc_block_mem #(
	parameter int N = 16,
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	sfc_mem_if.mem   port
);
	logic [W-1:0] store [N];

	// set wins over a bulk clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < N; i++) begin
				store[i] <= '0;
			end
		end else if (clkEn) begin
			for (int i = 0; i < N; i++) begin
				if (port.wrEn && port.wrIdx == i[$clog2(N)-1:0]) begin
					store[i] <= (store[i] & ~port.clrAll) | port.wrSet;
				end else begin
					store[i] <= store[i] & ~port.clrAll;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port.rdData <= '0;
		end else if (clkEn) begin
			port.rdData <= store[port.rdIdx];
		end
	end
endmodule : sfc_block_mem

// ===== verilog/sfc_command_unit.sv
// command interpreter, status registers and configuration of the flash
// Notes on behaviour
// - address valid low at clock edge, selected, write high latches read address
// - selected only with both chip enables low; otherwise data outputs float
// - identifier: low address bit picks maker or device code; other bits zero
// - ready/busy pulled low only while the machine runs an operation
// - write, erase and lock only complete with programming supply in range
// - word or byte write is 40H or 10H then address and data
// - erase 20H+D0H, suspend B0H, resume D0H, read array FFH, lock 77H+D0H
// - after 90H reads return maker and device signatures
// - 70H or starting write, erase or suspend switches reads to status
// - 50H clears compatible bits 3-5, global bit 5, block bits 5,4,2
// - upper data byte ignored in command writes
// - 71H reads global or block status; locks read locked until 97H+D0H
// - 96H then data sets the burst latency configuration
// - compatible status: ready, suspended, erase error, write error, supply error
// - improper erase sequence sets both erase and write error
// - supply sampled only when a write, erase or lock sequence is entered
// - global status: ready, suspended, operation failed
// - block status: ready, unlocked, failed, supply error, 5 V level
// - latency select in bits 5-3, codes 1 to 4
// - latency defaults to 4 at power-up and after deep power-down
// - reset pin low aborts operation, clears status, returns to read array
// - write protect low refuses write and erase to locked blocks
`timescale 1ns/1ps
module sfc_command_unit
	import sfc_pkg::*;
#(
	parameter int          WRITE_CYC  = WRITE_CYC_DEF,
	parameter int          ERASE_CYC  = ERASE_CYC_DEF,
	parameter int          LOCK_CYC   = LOCK_CYC_DEF,
	parameter int          UPLOAD_CYC = UPLOAD_CYC_DEF,
	parameter logic [15:0] MFR_CODE   = MFR_CODE_DEF,
	parameter logic [15:0] DEV_CODE   = DEV_CODE_DEF
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              clkEn,
	input  wire logic              resetPowerdownN,
	input  wire logic              ce0N,
	input  wire logic              ce1N,
	input  wire logic              oeN,
	input  wire logic              weN,
	input  wire logic              addrValidN,
	input  wire logic              byteN,
	input  wire logic              wpN,
	input  wire logic              supplyOk,
	input  wire logic              supplyIs5v,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] dqIn,
	input  wire logic [DATA_W-1:0] arrayData,
	output logic      [DATA_W-1:0] dqOut,
	output logic                   dqOe,
	output logic                   readyBusyOut,
	output logic                   readyBusyOe,
	output logic      [ADDR_W-1:0] readAddr,
	output logic                   bankOdd,
	output logic      [2:0]        latencySelect
);
	localparam int PIN_W = 10 + ADDR_W + DATA_W;
	localparam logic [PIN_W-1:0] PIN_IDLE = {8'hFF, 2'h0, {(ADDR_W + DATA_W){1'b0}}};

	logic [PIN_W-1:0]  pinMeta;
	logic [PIN_W-1:0]  pinSync;
	logic              pdnS, ce0S, ce1S, oeS, weS, avS, byteS, wpS, supOkS, sup5vS;
	logic [ADDR_W-1:0] addrS;
	logic [DATA_W-1:0] dqS;
	logic              weLast;
	sfc_read_mode_t    readMode, next_readMode;
	sfc_pend_t         pend, next_pend;
	sfc_machine_t      machine;
	logic [CNT_W-1:0]  opCount;
	logic [BLK_W-1:0]  opBlk;
	logic              eraseErr, writeErr, supplyErr, opFail;
	logic [NUM_BLOCKS-1:0] lockShown;
	logic [NUM_BLOCKS-1:0] lockNv;
	logic [BLK_W-1:0]  rdBlk;

	// every pin but arrayData is asynchronous to clk; two stages before use
	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta <= PIN_IDLE;
			pinSync <= PIN_IDLE;
		end else if (clkEn) begin
			pinMeta <= {resetPowerdownN, ce0N, ce1N, oeN, weN, addrValidN, byteN, wpN,
				supplyOk, supplyIs5v, addr, dqIn};
			pinSync <= pinMeta;
		end
	end
	assign {pdnS, ce0S, ce1S, oeS, weS, avS, byteS, wpS, supOkS, sup5vS, addrS, dqS} = pinSync;

	logic             selected, powerDown, weRise, machineBusy, suspended;
	logic [7:0]       cmd;
	logic [BLK_W-1:0] blkIdx;
	assign selected    = !ce0S && !ce1S;
	assign powerDown   = !pdnS;
	// address and data are held by the host around the strobe, so the synced copy is stable
	assign weRise      = selected && weS && !weLast && !powerDown;
	assign cmd         = dqS[7:0];
	assign blkIdx      = addrS[BLK_LSB +: BLK_W];
	assign suspended   = machine == MS_SUSPEND;
	assign machineBusy = machine != MS_IDLE && !suspended;

	always_ff @(posedge clk) begin
		if (rst) begin
			weLast <= 1'b1;
		end else if (clkEn) begin
			weLast <= weS;
		end
	end

	// command decode
	logic         doStart, doClear, cfgWr, suspendReq, resumeReq, eraseSeqErr, lockSeqErr;
	sfc_machine_t startKind;
	always_comb begin
		next_readMode = readMode;
		next_pend     = pend;
		doStart       = 1'b0;
		startKind     = MS_WRITE;
		doClear       = 1'b0;
		cfgWr         = 1'b0;
		suspendReq    = 1'b0;
		resumeReq     = 1'b0;
		eraseSeqErr   = 1'b0;
		lockSeqErr    = 1'b0;
		if (weRise) begin
			if (pend != PD_NONE) begin
				next_pend = PD_NONE;
				unique case (pend)
					PD_WRITE: begin
						doStart       = 1'b1;
						startKind     = MS_WRITE;
						next_readMode = RM_STATUS;
					end
					PD_ERASE: begin
						doStart       = cmd == CMD_CONFIRM;
						eraseSeqErr   = cmd != CMD_CONFIRM;
						startKind     = MS_ERASE;
						next_readMode = RM_STATUS;
					end
					PD_LOCK: begin
						doStart    = cmd == CMD_CONFIRM;
						lockSeqErr = cmd != CMD_CONFIRM;
						startKind  = MS_LOCK;
					end
					PD_UPLOAD: begin
						doStart    = cmd == CMD_CONFIRM;
						lockSeqErr = cmd != CMD_CONFIRM;
						startKind  = MS_UPLOAD;
					end
					PD_CONFIG: cfgWr = 1'b1;
					default: ;
				endcase
			end else if (machineBusy) begin
				// while busy only status reads and suspend are honoured
				if (cmd == CMD_READ_STAT) begin
					next_readMode = RM_STATUS;
				end else if (cmd == CMD_READ_XSTAT) begin
					next_readMode = RM_XSTATUS;
				end else if (cmd == CMD_SUSPEND && machine == MS_ERASE) begin
					suspendReq    = 1'b1;
					next_readMode = RM_STATUS;
				end
			end else begin
				unique case (cmd)
					CMD_READ_ARRAY: next_readMode = RM_ARRAY;
					CMD_IDENT:      next_readMode = RM_IDENT;
					CMD_READ_STAT:  next_readMode = RM_STATUS;
					CMD_READ_XSTAT: next_readMode = RM_XSTATUS;
					CMD_CLEAR:      doClear = 1'b1;
					CMD_WRITE, CMD_WRITE_ALT: next_pend = suspended ? PD_NONE : PD_WRITE;
					CMD_ERASE:      next_pend = suspended ? PD_NONE : PD_ERASE;
					CMD_LOCK:       next_pend = suspended ? PD_NONE : PD_LOCK;
					CMD_UPLOAD:     next_pend = suspended ? PD_NONE : PD_UPLOAD;
					CMD_CONFIG:     next_pend = PD_CONFIG;
					CMD_CONFIRM: begin
						resumeReq     = suspended;
						next_readMode = suspended ? RM_STATUS : readMode;
					end
					default: ;
				endcase
			end
		end
	end

	// operation launch checks
	logic needSupply, abortSupply, refuseLock, startOk, opDone;
	assign needSupply  = startKind != MS_UPLOAD;
	assign abortSupply = doStart && needSupply && !supOkS;
	assign refuseLock  = doStart && !abortSupply && (startKind == MS_WRITE ||
		startKind == MS_ERASE) && !wpS && !lockShown[blkIdx];
	assign startOk     = doStart && !abortSupply && !refuseLock;
	assign opDone      = machineBusy && opCount == '0;

	function automatic logic [CNT_W-1:0] opLen(sfc_machine_t k);
		unique case (k)
			MS_ERASE:  opLen = CNT_W'(ERASE_CYC - 1);
			MS_LOCK:   opLen = CNT_W'(LOCK_CYC - 1);
			MS_UPLOAD: opLen = CNT_W'(UPLOAD_CYC - 1);
			default:   opLen = CNT_W'(WRITE_CYC - 1);
		endcase
	endfunction : opLen

	// read mode and pending second cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			readMode <= RM_ARRAY;
			pend     <= PD_NONE;
		end else if (clkEn) begin
			if (powerDown) begin
				readMode <= RM_ARRAY;
				pend     <= PD_NONE;
			end else begin
				readMode <= next_readMode;
				pend     <= next_pend;
			end
		end
	end

	// write state machine
	always_ff @(posedge clk) begin
		if (rst) begin
			machine <= MS_IDLE;
			opCount <= '0;
			opBlk   <= '0;
		end else if (clkEn) begin
			if (powerDown) begin
				machine <= MS_IDLE;
			end else if (startOk) begin
				machine <= startKind;
				opCount <= opLen(startKind);
				opBlk   <= blkIdx;
			end else if (suspendReq) begin
				machine <= MS_SUSPEND;
			end else if (resumeReq) begin
				machine <= MS_ERASE;
			end else if (opDone) begin
				machine <= MS_IDLE;
			end else if (machineBusy) begin
				opCount <= opCount - 1'b1;
			end
		end
	end

	// status flags: a set in the same cycle as a clear wins
	logic setEraseErr, setWriteErr, setOpFail;
	assign setEraseErr = ((abortSupply || refuseLock) && startKind == MS_ERASE) || eraseSeqErr;
	assign setWriteErr = ((abortSupply || refuseLock) && startKind == MS_WRITE) || eraseSeqErr;
	assign setOpFail   = abortSupply || refuseLock || eraseSeqErr || lockSeqErr;
	always_ff @(posedge clk) begin
		if (rst) begin
			eraseErr  <= 1'b0;
			writeErr  <= 1'b0;
			supplyErr <= 1'b0;
			opFail    <= 1'b0;
		end else if (clkEn) begin
			if (powerDown) begin
				eraseErr  <= 1'b0;
				writeErr  <= 1'b0;
				supplyErr <= 1'b0;
				opFail    <= 1'b0;
			end else begin
				eraseErr  <= (eraseErr && !doClear) || setEraseErr;
				writeErr  <= (writeErr && !doClear) || setWriteErr;
				supplyErr <= (supplyErr && !doClear) || abortSupply;
				opFail    <= (opFail && !doClear) || setOpFail;
			end
		end
	end

	// lock bits: the nonvolatile copy survives power-down, the shown copy does not
	always_ff @(posedge clk) begin
		if (rst) begin
			lockNv    <= '0;
			lockShown <= '0;
		end else if (clkEn) begin
			if (powerDown) begin
				lockShown <= '0;
			end else if (opDone && machine == MS_LOCK) begin
				lockNv[opBlk]    <= 1'b1;
				lockShown[opBlk] <= 1'b0;
			end else if (opDone && machine == MS_UPLOAD) begin
				lockShown <= ~lockNv;
			end
		end
	end

	// latency configuration; undefined codes are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			latencySelect <= LAT_DEFAULT;
		end else if (clkEn) begin
			if (powerDown) begin
				latencySelect <= LAT_DEFAULT;
			end else if (cfgWr && dqS[CFG_LAT_LSB +: 3] >= LAT_MIN &&
				dqS[CFG_LAT_LSB +: 3] <= LAT_MAX) begin
				latencySelect <= dqS[CFG_LAT_LSB +: 3];
			end
		end
	end

	// per-block failure flags
	sfc_mem_if #(.N(NUM_BLOCKS), .W(MEM_W)) memPort ();
	sfc_block_mem #(.N(NUM_BLOCKS), .W(MEM_W)) blockMem (
		.clk   (clk),
		.rst   (rst),
		.clkEn (clkEn),
		.port  (memPort.mem)
	);
	assign memPort.wrEn  = (abortSupply || refuseLock) && !powerDown;
	assign memPort.wrIdx = blkIdx;
	// failure bit always, supply bit only when the supply caused the abort
	assign memPort.wrSet = (MEM_W'(1'b1) << BLK_FAIL_BIT) | (MEM_W'(abortSupply) << BLK_SUPPLY_BIT);
	// block flags 5, 4 and 2 cleared by the clear command, all of them on power-down
	assign memPort.clrAll = powerDown ? '1 : (doClear ? 8'h34 : 8'h00);
	assign memPort.rdIdx  = readAddr[BLK_LSB +: BLK_W];

	// read address latch
	always_ff @(posedge clk) begin
		if (rst) begin
			readAddr <= '0;
			bankOdd  <= 1'b0;
			rdBlk    <= '0;
		end else if (clkEn) begin
			if (selected && !avS && weS && !powerDown) begin
				readAddr <= addrS;
				bankOdd  <= addrS[1];
			end
			rdBlk <= readAddr[BLK_LSB +: BLK_W];
		end
	end

	// read data mux; block status lags the address latch by one cycle
	logic [7:0]        compatStatus, globalStatus, blockStatus;
	logic [DATA_W-1:0] idWord, next_dq;
	logic              idSel, idClean;
	assign compatStatus = {!machineBusy, suspended, eraseErr, writeErr, supplyErr, 3'h0};
	assign globalStatus = {!machineBusy, suspended, opFail, 5'h00};
	assign blockStatus  = {!(machineBusy && opBlk == rdBlk), lockShown[rdBlk],
		memPort.rdData[BLK_FAIL_BIT], 2'h0, memPort.rdData[BLK_SUPPLY_BIT], sup5vS, 1'b0};
	assign idSel   = byteS ? readAddr[1] : readAddr[0];
	assign idClean = byteS ? readAddr[ADDR_W-1:2] == '0 : readAddr[ADDR_W-1:1] == '0;
	assign idWord  = !idClean ? '0 : (idSel ? DEV_CODE : MFR_CODE);

	always_comb begin
		next_dq = '0;
		unique case (readMode)
			RM_ARRAY:   next_dq = arrayData;
			RM_IDENT:   next_dq = idWord;
			RM_STATUS:  next_dq = {8'h00, compatStatus};
			RM_XSTATUS: begin
				if (readAddr[XSEL_LSB +: 2] == XSEL_BLOCK) begin
					next_dq = {8'h00, blockStatus};
				end else if (readAddr[XSEL_LSB +: 2] == XSEL_GLOBAL) begin
					next_dq = {8'h00, globalStatus};
				end
			end
		endcase
		if (!byteS) begin
			// byte mode: upper lines driven to zero, low byte only, a0 picks array byte
			next_dq = {8'h00, (readMode == RM_ARRAY && readAddr[0]) ? next_dq[15:8] : next_dq[7:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dqOut        <= '0;
			dqOe         <= 1'b0;
			readyBusyOut <= 1'b0;
			readyBusyOe  <= 1'b0;
		end else if (clkEn) begin
			dqOut        <= next_dq;
			dqOe         <= selected && !oeS && weS && !powerDown;
			readyBusyOut <= 1'b0;
			readyBusyOe  <= machineBusy && !powerDown;
		end
	end

	a_ready_busy_pin: assert property (@(posedge clk) disable iff (rst)
		clkEn |=> readyBusyOe == $past(machineBusy && pdnS)) else $error("ready/busy wrong");
	a_high_byte_ignored: assert property (@(posedge clk) disable iff (rst)
		clkEn && weRise && pend == PD_NONE && !machineBusy && cmd == CMD_READ_ARRAY
		|=> readMode == RM_ARRAY) else $error("command not decoded from low byte");
	a_clear_status: assert property (@(posedge clk) disable iff (rst)
		clkEn && doClear |=> !eraseErr && !writeErr && !supplyErr && !opFail)
		else $error("clear left a flag set");
	a_supply_abort: assert property (@(posedge clk) disable iff (rst)
		clkEn && abortSupply && pdnS |=> supplyErr && machine == MS_IDLE ##1 !readyBusyOe)
		else $error("supply abort not taken");
	a_erase_sequence: assert property (@(posedge clk) disable iff (rst)
		clkEn && eraseSeqErr && pdnS |=> eraseErr && writeErr) else $error("bad erase unflagged");
	a_protect_refuse: assert property (@(posedge clk) disable iff (rst)
		clkEn && refuseLock && pdnS |=> machine == MS_IDLE && opFail)
		else $error("locked block altered");
	a_status_auto: assert property (@(posedge clk) disable iff (rst)
		clkEn && startOk && pdnS && (startKind == MS_WRITE || startKind == MS_ERASE)
		|=> readMode == RM_STATUS) else $error("no status after start");
	a_power_down: assert property (@(posedge clk) disable iff (rst)
		clkEn && powerDown |=> machine == MS_IDLE && readMode == RM_ARRAY &&
		latencySelect == LAT_DEFAULT && !readyBusyOe && !dqOe) else $error("power-down incomplete");
	a_deselect_float: assert property (@(posedge clk) disable iff (rst)
		clkEn && !selected |=> !dqOe) else $error("outputs driven while deselected");
	a_addr_latch: assert property (@(posedge clk) disable iff (rst)
		clkEn && selected && !avS && weS && pdnS |=> readAddr == $past(addrS))
		else $error("read address not latched");
	a_suspend_state: assert property (@(posedge clk) disable iff (rst)
		clkEn && suspendReq && pdnS |=> compatStatus[7:6] == 2'h3 ##1 !readyBusyOe)
		else $error("suspend not reported");
	c_write_done: cover property (@(posedge clk) disable iff (rst) opDone && machine == MS_WRITE);
	c_erase_suspend: cover property (@(posedge clk) disable iff (rst) suspendReq);
	c_upload_done: cover property (@(posedge clk) disable iff (rst) opDone && machine == MS_UPLOAD);
	c_config_write: cover property (@(posedge clk) disable iff (rst) cfgWr);
endmodule : sfc_command_unit

// ===== verification/sfc_host_model.sv
// host side model that drives the flash bus pins
`timescale 1ns/1ps
module sfc_host_model
	import sfc_pkg::*;
(
	input  wire logic              clk,
	output logic                   ce0N,
	output logic                   ce1N,
	output logic                   oeN,
	output logic                   weN,
	output logic                   addrValidN,
	output logic      [ADDR_W-1:0] addr,
	output logic      [DATA_W-1:0] dqIn
);
	initial begin
		{ce0N, ce1N, oeN, weN, addrValidN} = 5'h1F;
		addr = '0;
		dqIn = 16'hFFFF;
	end
	// each call is one write cycle of a command; the sync needs three clocks per level
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		{ce0N, ce1N, oeN} = 3'h1;
		addr = a;
		dqIn = d;
		weN = 1'b0;
		repeat (3) @(negedge clk);
		weN = 1'b1;
		repeat (3) @(negedge clk);
		dqIn = ~d; // released bus does not keep the last value
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(negedge clk);
		{ce0N, ce1N} = 2'h0;
		addr = a;
		addrValidN = 1'b0;
		oeN = 1'b0;
		repeat (3) @(negedge clk);
		addrValidN = 1'b1;
		repeat (5) @(negedge clk);
	endtask : rd
	task automatic sel(input logic on);
		ce1N = ~on;
	endtask : sel
endmodule : sfc_host_model

// ===== verification/sync_flash_command_status_unit_bench.sv
// self-checking bench for the flash command and status unit
`timescale 1ns/1ps
module sync_flash_command_status_unit_bench
	import sfc_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wpN = 1'b1, supplyOk = 1'b1, resetPowerdownN = 1'b1;
	logic clkEn = 1'b1, byteN = 1'b1, supplyIs5v = 1'b0;
	logic ce0N, ce1N, oeN, weN, addrValidN, dqOe, readyBusyOut, readyBusyOe, bankOdd;
	logic [ADDR_W-1:0] addr, readAddr;
	logic [DATA_W-1:0] dqIn, dqOut;
	logic [DATA_W-1:0] arrayData = 16'h0000;
	logic [2:0]        latencySelect;
	int                err_total = 0;
	int                compares = 0;
	always #25 clk = ~clk;
	sfc_host_model host (.clk(clk), .ce0N(ce0N), .ce1N(ce1N), .oeN(oeN), .weN(weN),
		.addrValidN(addrValidN), .addr(addr), .dqIn(dqIn));
	// short operation counts keep the run brief; erase long enough to suspend
	sfc_command_unit #(.WRITE_CYC(4), .ERASE_CYC(40), .LOCK_CYC(4), .UPLOAD_CYC(4)) uut (
		.clk(clk), .rst(rst), .clkEn(clkEn), .resetPowerdownN(resetPowerdownN), .ce0N(ce0N),
		.ce1N(ce1N), .oeN(oeN), .weN(weN), .addrValidN(addrValidN), .byteN(byteN),
		.wpN(wpN), .supplyOk(supplyOk), .supplyIs5v(supplyIs5v), .addr(addr), .dqIn(dqIn),
		.arrayData(arrayData), .dqOut(dqOut), .dqOe(dqOe), .readyBusyOut(readyBusyOut),
		.readyBusyOe(readyBusyOe), .readAddr(readAddr), .bankOdd(bankOdd),
		.latencySelect(latencySelect));
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// reserved status bits masked, host habit when polling
	task automatic st(input string n, input logic [7:0] e);
		chk(n, {8'h00, e}, {8'h00, dqOut[7:0] & 8'hF8});
	endtask : st
	task automatic wait_rb(input logic lvl);
		int n;
		n = 0;
		while (readyBusyOe !== lvl && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (readyBusyOe !== lvl) begin
			err_total++;
			$display("mismatch readyBusyOe expected %b seen %b", lvl, readyBusyOe);
			give_verdict();
		end
	endtask : wait_rb
	task automatic t_status;
		chk("latency", 16'(LAT_DEFAULT), 16'(latencySelect));
		chk("busy idle", 16'h0, 16'(readyBusyOe));
		host.wr('0, 16'hAB70);
		host.rd('0);
		st("status", 8'h80);
		chk("dqOe on", 16'h1, 16'(dqOe));
		host.sel(1'b0);
		repeat (4) @(negedge clk);
		chk("dqOe off", 16'h0, 16'(dqOe));
		host.sel(1'b1);
		$display("test status done");
	endtask : t_status
	task automatic t_erase;
		host.wr('0, 16'h0020);
		host.wr(21'h060000, 16'h00D0);
		wait_rb(1'b1);
		chk("busy level", 16'h0, 16'(readyBusyOut));
		host.wr('0, 16'h00B0);
		host.rd('0);
		st("suspended", 8'hC0);
		chk("busy suspended", 16'h0, 16'(readyBusyOe));
		host.wr('0, 16'h00D0);
		wait_rb(1'b1);
		wait_rb(1'b0);
		host.rd('0);
		st("erase done", 8'h80);
		$display("test erase done");
	endtask : t_erase
	task automatic t_faults;
		wpN = 1'b0;
		host.wr('0, 16'h0020);
		host.wr(21'h020000, 16'h00D0);
		host.rd('0);
		st("locked erase", 8'hA0);
		wpN = 1'b1;
		host.wr('0, 16'h0050);
		host.wr('0, 16'h0070);
		host.rd('0);
		st("cleared", 8'h80);
		host.wr('0, 16'h0020);
		host.wr('0, 16'h00FF);
		host.wr('0, 16'h0070);
		host.rd('0);
		st("bad sequence", 8'hB0);
		host.wr('0, 16'h0050);
		supplyOk = 1'b0;
		host.wr('0, 16'h0040);
		host.wr(21'h000100, 16'h1234);
		supplyOk = 1'b1;
		host.wr('0, 16'h0070);
		host.rd('0);
		st("supply", 8'h98);
		host.wr('0, 16'h0071);
		host.rd(21'h000002);
		chk("block fail", 16'h00A4, dqOut);
		supplyIs5v = 1'b1;
		host.rd(21'h000002);
		chk("block 5v", 16'h00A6, dqOut);
		host.rd(21'h000004);
		chk("global fail", 16'h00A0, dqOut);
		host.wr('0, 16'h0050);
		host.wr('0, 16'h0070);
		host.rd('0);
		st("cleared again", 8'h80);
		$display("test faults done");
	endtask : t_faults
	task automatic t_lock;
		host.wr('0, 16'h0077);
		host.wr(21'h040000, 16'h00D0);
		wait_rb(1'b1);
		wait_rb(1'b0);
		host.wr('0, 16'h0097);
		host.wr('0, 16'h00D0);
		wait_rb(1'b1);
		wait_rb(1'b0);
		host.wr('0, 16'h0071);
		host.rd(21'h040002);
		chk("block locked", 16'h0082, dqOut);
		host.rd(21'h060002);
		chk("block unlocked", 16'h00C2, dqOut);
		wpN = 1'b0;
		host.wr('0, 16'h0010);
		host.wr(21'h040010, 16'h5678);
		host.rd('0);
		st("locked write", 8'h90);
		wpN = 1'b1;
		host.wr('0, 16'h0050);
		$display("test lock done");
	endtask : t_lock
	task automatic t_ident;
		host.wr('0, 16'h0090);
		host.rd('0);
		chk("maker", MFR_CODE_DEF, dqOut);
		chk("even bank", 16'h0, 16'(bankOdd));
		host.rd(21'h000002);
		chk("device", DEV_CODE_DEF, dqOut);
		chk("odd bank", 16'h1, 16'(bankOdd));
		chk("read address", 16'h0002, readAddr[15:0]);
		byteN = 1'b0;
		host.rd(21'h000001);
		chk("device x8", {8'h00, DEV_CODE_DEF[7:0]}, dqOut);
		host.rd('0);
		chk("maker x8", {8'h00, MFR_CODE_DEF[7:0]}, dqOut);
		host.wr('0, 16'h5AFF);
		arrayData = 16'hC3A5;
		host.rd(21'h000001);
		chk("array x8", 16'h00C3, dqOut);
		byteN = 1'b1;
		host.rd('0);
		chk("array x16", 16'hC3A5, dqOut);
		$display("test ident done");
	endtask : t_ident
	task automatic t_config;
		host.wr('0, 16'h0096);
		host.wr('0, 16'h0010);
		repeat (3) @(negedge clk);
		chk("latency set", 16'h2, 16'(latencySelect));
		host.wr('0, 16'h0096);
		host.wr('0, 16'h0028);
		repeat (3) @(negedge clk);
		chk("latency kept", 16'h2, 16'(latencySelect));
		// clock enable low: the pin pulse is never sampled
		clkEn = 1'b0;
		resetPowerdownN = 1'b0;
		repeat (4) @(negedge clk);
		resetPowerdownN = 1'b1;
		clkEn = 1'b1;
		repeat (4) @(negedge clk);
		chk("latency frozen", 16'h2, 16'(latencySelect));
		resetPowerdownN = 1'b0;
		repeat (4) @(negedge clk);
		resetPowerdownN = 1'b1;
		repeat (4) @(negedge clk);
		chk("latency back", 16'(LAT_DEFAULT), 16'(latencySelect));
		$display("test config done");
	endtask : t_config
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_status();
		t_erase();
		t_faults();
		t_lock();
		t_ident();
		t_config();
		give_verdict();
	end
endmodule : sync_flash_command_status_unit_bench
